// ==== hw/clock_select_and_output_enable.sv ====
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module clock_select_and_output_enable #(
    // Reduced variant parks the adapter pin low
    parameter logic REDUCED_VARIANT = 1'b0
) (
    // Clock, reset and enable
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Clock pins, asynchronous
    input  wire logic        rx_sysbus_clk_pin_i,
    input  wire logic        tx_sysbus_clk_pin_i,
    input  wire logic        adapter_ref_pin_i,
    input  wire logic        tx_line_clk_pin_i,
    // Internal sources, same clock
    input  wire logic        adapter_clk_int_i,
    input  wire logic        rx_recovered_clk_int_i,
    input  wire logic        attenuator_clock_i,
    input  wire logic        tx_link_clk_int_i,
    input  wire logic        rx_neg_or_link_clk_int_i,
    input  wire logic        rx_pos_or_link_data_int_i,
    input  wire logic        tx_neg_or_rx_indication_int_i,
    input  wire logic        tx_pos_or_tx_indication_int_i,
    // Selected internal clocks
    output logic             rx_sysbus_clk_o,
    output logic             tx_sysbus_clk_o,
    output logic             adapter_ref_o,
    output logic             tx_line_clk_o,
    // Pads, value and enable
    output logic             tx_line_clk_out_o,
    output logic             tx_line_clk_out_oe_o,
    output logic             adapter_clk_out_o,
    output logic             adapter_clk_out_oe_o,
    output logic             rx_recovered_clk_out_o,
    output logic             rx_recovered_clk_out_oe_o,
    output logic             tx_link_clk_out_o,
    output logic             tx_link_clk_out_oe_o,
    output logic             rx_neg_or_link_clk_out_o,
    output logic             rx_neg_or_link_clk_out_oe_o,
    output logic             rx_pos_or_link_data_out_o,
    output logic             rx_pos_or_link_data_out_oe_o,
    output logic             tx_neg_or_rx_indication_o,
    output logic             tx_neg_or_rx_indication_oe_o,
    output logic             tx_pos_or_tx_indication_o,
    output logic             tx_pos_or_tx_indication_oe_o
);

    ////////////////////////////////////////////////////////////////////
    // One of four clock sources
    function automatic logic pick4(input logic [1:0] sel,
                                   input logic a, input logic b,
                                   input logic c, input logic d);
        case (sel)
            clock_select_pkg::SEL_A: pick4 = a;
            clock_select_pkg::SEL_B: pick4 = b;
            clock_select_pkg::SEL_C: pick4 = c;
            default:                 pick4 = d;
        endcase
    endfunction

    // Word-aligned address of a mapped register
    function automatic logic addr_known(input logic [7:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        addr_known = (a[1:0] == 2'h0) &&
                     (idx == clock_select_pkg::BUF_EN_IDX   ||
                      idx == clock_select_pkg::CLK_SEL_IDX  ||
                      idx == clock_select_pkg::TEST_SEL_IDX ||
                      idx == clock_select_pkg::PATH_CTL_IDX ||
                      idx == clock_select_pkg::STATUS_IDX);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int NP = clock_select_pkg::PIN_COUNT;

    logic [NP-1:0] pin_meta;
    logic [NP-1:0] pin_sync;
    logic [NP-1:0] pins_raw;
    logic [NP-1:0] next_pin_meta;
    logic [NP-1:0] next_pin_sync;

    assign pins_raw[clock_select_pkg::PIN_RX_SYSBUS] = rx_sysbus_clk_pin_i;
    assign pins_raw[clock_select_pkg::PIN_TX_SYSBUS] = tx_sysbus_clk_pin_i;
    assign pins_raw[clock_select_pkg::PIN_ADAPTER]   = adapter_ref_pin_i;
    assign pins_raw[clock_select_pkg::PIN_TX_LINE]   = tx_line_clk_pin_i;

    // First stage feeds only the second stage
    always_comb begin
        next_pin_meta = pins_raw;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (ce_i) begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file and APB slave
    logic [5:0]  output_buffer_enables;
    logic [7:0]  clock_source_select;
    logic [5:0]  factory_test_select;
    logic [5:0]  path_control;
    logic [5:0]  next_buf_en;
    logic [7:0]  next_clk_sel;
    logic [5:0]  next_test_sel;
    logic [5:0]  next_path_ctl;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] status_word;
    logic        access;
    logic        commit;
    logic        nrz_mode;
    logic        atten_tx;

    assign access = psel_i & penable_i;
    // Write lands only at the edge that completes the access
    assign commit = access & pready_o & pwrite_i & ~pslverr_o & pstrb_i[0];

    // Live view of the block's own decisions
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[clock_select_pkg::NRZ_MODE_BIT]   = nrz_mode;
        status_word[clock_select_pkg::ATTEN_PATH_BIT] = atten_tx;
        status_word[clock_select_pkg::CLK_VIEW_LSB +: 4] =
            {tx_line_clk_o, adapter_ref_o, tx_sysbus_clk_o, rx_sysbus_clk_o};
    end

    // One wait state so that read data leaves a flip-flop
    always_comb begin
        next_buf_en   = output_buffer_enables;
        next_clk_sel  = clock_source_select;
        next_test_sel = factory_test_select;
        next_path_ctl = path_control;
        next_prdata   = prdata_o;
        next_pready   = access & ~pready_o;
        next_pslverr  = 1'b0;
        if (access && !pready_o) begin
            next_pslverr = ~addr_known(paddr_i) |
                (pwrite_i &&
                 paddr_i[7:2] == clock_select_pkg::STATUS_IDX);
            case (paddr_i[7:2])
                clock_select_pkg::BUF_EN_IDX:
                    next_prdata = {26'h0, output_buffer_enables};
                clock_select_pkg::CLK_SEL_IDX:
                    next_prdata = {24'h0, clock_source_select};
                clock_select_pkg::TEST_SEL_IDX:
                    next_prdata = {26'h0, factory_test_select};
                clock_select_pkg::PATH_CTL_IDX:
                    next_prdata = {26'h0, path_control};
                clock_select_pkg::STATUS_IDX:
                    next_prdata = status_word;
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end
        if (commit) begin
            case (paddr_i[7:2])
                clock_select_pkg::BUF_EN_IDX:
                    next_buf_en = pwdata_i[5:0];
                clock_select_pkg::CLK_SEL_IDX:
                    next_clk_sel = pwdata_i[7:0];
                clock_select_pkg::TEST_SEL_IDX:
                    next_test_sel = pwdata_i[5:0];
                clock_select_pkg::PATH_CTL_IDX:
                    next_path_ctl = pwdata_i[5:0];
                default:
                    next_path_ctl = path_control;
            endcase
        end
    end

    // Unwritten state resets three-stated to keep shared buses safe
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            output_buffer_enables <= clock_select_pkg::BUF_EN_RESET;
            clock_source_select   <= clock_select_pkg::CLK_SEL_RESET;
            factory_test_select   <= clock_select_pkg::TEST_SEL_RESET;
            path_control          <= clock_select_pkg::PATH_CTL_RESET;
            prdata_o              <= 32'h0000_0000;
            pready_o              <= 1'b0;
            pslverr_o             <= 1'b0;
        end else if (ce_i) begin
            output_buffer_enables <= next_buf_en;
            clock_source_select   <= next_clk_sel;
            factory_test_select   <= next_test_sel;
            path_control          <= next_path_ctl;
            prdata_o              <= next_prdata;
            pready_o              <= next_pready;
            pslverr_o             <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock routing and pad control
    logic next_rx_sysbus;
    logic next_tx_sysbus;
    logic next_adapter_ref;
    logic next_tx_line;
    logic next_tx_line_out;
    logic [7:0] next_oe;

    // NRZ needs the select bit and all three line outputs enabled
    assign nrz_mode = path_control[clock_select_pkg::NRZ_SELECT_BIT] &
        ~output_buffer_enables[clock_select_pkg::INDICATION_BIT] &
        ~output_buffer_enables[clock_select_pkg::TX_LINE_HIZ_BIT];
    assign atten_tx = path_control[clock_select_pkg::ATTEN_EN_BIT] &
        path_control[clock_select_pkg::ATTEN_TX_BIT];

    // Pins are seen two cycles late; fine for line-rate clocks
    always_comb begin
        next_rx_sysbus = pick4(
            clock_source_select[clock_select_pkg::RX_SYSBUS_LSB +: 2],
            pin_sync[clock_select_pkg::PIN_RX_SYSBUS],
            pin_sync[clock_select_pkg::PIN_TX_SYSBUS],
            pin_sync[clock_select_pkg::PIN_ADAPTER],
            adapter_clk_int_i);
        next_tx_sysbus = pick4(
            clock_source_select[clock_select_pkg::TX_SYSBUS_LSB +: 2],
            pin_sync[clock_select_pkg::PIN_TX_SYSBUS],
            pin_sync[clock_select_pkg::PIN_RX_SYSBUS],
            pin_sync[clock_select_pkg::PIN_ADAPTER],
            adapter_clk_int_i);
        if (path_control[clock_select_pkg::SLIP_BYPASS_BIT]) begin
            next_tx_sysbus = 1'b0;
        end
        next_adapter_ref = 1'b0;
        if (path_control[clock_select_pkg::ADAPTER_EN_BIT]) begin
            next_adapter_ref = pick4(
                clock_source_select[clock_select_pkg::ADAPTER_LSB +: 2],
                pin_sync[clock_select_pkg::PIN_ADAPTER],
                rx_recovered_clk_int_i,
                pin_sync[clock_select_pkg::PIN_TX_SYSBUS],
                pin_sync[clock_select_pkg::PIN_TX_LINE]);
        end
        next_tx_line = pick4(
            clock_source_select[clock_select_pkg::TX_LINE_LSB +: 2],
            pin_sync[clock_select_pkg::PIN_TX_LINE],
            rx_recovered_clk_int_i,
            pin_sync[clock_select_pkg::PIN_RX_SYSBUS],
            adapter_clk_int_i);
        // NRZ mode wins over the attenuator path
        if (!nrz_mode && atten_tx) begin
            next_tx_line_out = attenuator_clock_i;
        end else begin
            next_tx_line_out = next_tx_line;
        end
    end

    // Pad enables, active high while driving
    always_comb begin
        next_oe[0] = ~output_buffer_enables[
            clock_select_pkg::TX_LINE_HIZ_BIT];
        next_oe[1] = ~output_buffer_enables[
            clock_select_pkg::ADAPTER_HIZ_BIT];
        next_oe[2] = ~output_buffer_enables[
            clock_select_pkg::RX_CLK_HIZ_BIT];
        next_oe[3] = ~output_buffer_enables[
            clock_select_pkg::LINK_CLK_HIZ_BIT] &
            ~path_control[clock_select_pkg::LINK_DIR_IN_BIT];
        next_oe[4] = ~output_buffer_enables[
            clock_select_pkg::RX_LINK_HIZ_BIT];
        next_oe[5] = next_oe[4];
        next_oe[6] = ~output_buffer_enables[
            clock_select_pkg::INDICATION_BIT];
        next_oe[7] = next_oe[6];
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_sysbus_clk_o              <= 1'b0;
            tx_sysbus_clk_o              <= 1'b0;
            adapter_ref_o                <= 1'b0;
            tx_line_clk_o                <= 1'b0;
            tx_line_clk_out_o            <= 1'b0;
            adapter_clk_out_o            <= 1'b0;
            rx_recovered_clk_out_o       <= 1'b0;
            tx_link_clk_out_o            <= 1'b0;
            rx_neg_or_link_clk_out_o     <= 1'b0;
            rx_pos_or_link_data_out_o    <= 1'b0;
            tx_neg_or_rx_indication_o    <= 1'b0;
            tx_pos_or_tx_indication_o    <= 1'b0;
            tx_line_clk_out_oe_o         <= 1'b0;
            adapter_clk_out_oe_o         <= 1'b0;
            rx_recovered_clk_out_oe_o    <= 1'b0;
            tx_link_clk_out_oe_o         <= 1'b0;
            rx_neg_or_link_clk_out_oe_o  <= 1'b0;
            rx_pos_or_link_data_out_oe_o <= 1'b0;
            tx_neg_or_rx_indication_oe_o <= 1'b0;
            tx_pos_or_tx_indication_oe_o <= 1'b0;
        end else if (ce_i) begin
            rx_sysbus_clk_o              <= next_rx_sysbus;
            tx_sysbus_clk_o              <= next_tx_sysbus;
            adapter_ref_o                <= next_adapter_ref;
            tx_line_clk_o                <= next_tx_line;
            tx_line_clk_out_o            <= next_tx_line_out;
            adapter_clk_out_o            <= adapter_clk_int_i &
                                            ~REDUCED_VARIANT;
            rx_recovered_clk_out_o       <= rx_recovered_clk_int_i;
            tx_link_clk_out_o            <= tx_link_clk_int_i;
            rx_neg_or_link_clk_out_o     <= rx_neg_or_link_clk_int_i;
            rx_pos_or_link_data_out_o    <= rx_pos_or_link_data_int_i;
            tx_neg_or_rx_indication_o    <= tx_neg_or_rx_indication_int_i;
            tx_pos_or_tx_indication_o    <= tx_pos_or_tx_indication_int_i;
            tx_line_clk_out_oe_o         <= next_oe[0];
            adapter_clk_out_oe_o         <= next_oe[1];
            rx_recovered_clk_out_oe_o    <= next_oe[2];
            tx_link_clk_out_oe_o         <= next_oe[3];
            rx_neg_or_link_clk_out_oe_o  <= next_oe[4];
            rx_pos_or_link_data_out_oe_o <= next_oe[5];
            tx_neg_or_rx_indication_oe_o <= next_oe[6];
            tx_pos_or_tx_indication_oe_o <= next_oe[7];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    link_drive_a: assert property (
        ce_i && !output_buffer_enables[clock_select_pkg::LINK_CLK_HIZ_BIT]
        && !path_control[clock_select_pkg::LINK_DIR_IN_BIT]
        |=> tx_link_clk_out_oe_o
        && tx_link_clk_out_o == $past(tx_link_clk_int_i))
        else $error("link clock output not driven");

    link_dir_a: assert property (
        ce_i && path_control[clock_select_pkg::LINK_DIR_IN_BIT]
        |=> !tx_link_clk_out_oe_o)
        else $error("link pin driven while an input");

    rx_link_pair_a: assert property (
        ce_i |=> rx_neg_or_link_clk_out_oe_o == rx_pos_or_link_data_out_oe_o
        && rx_pos_or_link_data_out_oe_o != $past(
        output_buffer_enables[clock_select_pkg::RX_LINK_HIZ_BIT]))
        else $error("receive link enables wrong");

    indication_pair_a: assert property (
        ce_i |=> tx_neg_or_rx_indication_oe_o == tx_pos_or_tx_indication_oe_o
        && tx_pos_or_tx_indication_oe_o != $past(
        output_buffer_enables[clock_select_pkg::INDICATION_BIT]))
        else $error("indication enables wrong");

    line_clk_hiz_a: assert property (
        ce_i |=> tx_line_clk_out_oe_o != $past(
        output_buffer_enables[clock_select_pkg::TX_LINE_HIZ_BIT]))
        else $error("line clock enable wrong");

    adapter_hiz_a: assert property (
        ce_i |=> adapter_clk_out_oe_o != $past(
        output_buffer_enables[clock_select_pkg::ADAPTER_HIZ_BIT]))
        else $error("adapter clock enable wrong");

    // Checked on every build, so the full variant exercises it too
    adapter_low_a: assert property (
        ce_i |=> adapter_clk_out_o ==
        ($past(adapter_clk_int_i) & !REDUCED_VARIANT))
        else $error("adapter pin value wrong for variant");

    rx_clk_hiz_a: assert property (
        ce_i |=> rx_recovered_clk_out_oe_o != $past(
        output_buffer_enables[clock_select_pkg::RX_CLK_HIZ_BIT]))
        else $error("receive clock enable wrong");

    rx_sysbus_mux_a: assert property (
        ce_i && clock_source_select[7:6] == clock_select_pkg::SEL_D
        |=> rx_sysbus_clk_o == $past(adapter_clk_int_i))
        else $error("receive system bus clock source wrong");

    slip_bypass_a: assert property (
        ce_i && path_control[clock_select_pkg::SLIP_BYPASS_BIT]
        |=> !tx_sysbus_clk_o)
        else $error("system bus clock running in bypass");

    adapter_off_a: assert property (
        ce_i && !path_control[clock_select_pkg::ADAPTER_EN_BIT]
        |=> !adapter_ref_o)
        else $error("adapter reference active while disabled");

    line_mux_a: assert property (
        ce_i && clock_source_select[1:0] == clock_select_pkg::SEL_B
        |=> tx_line_clk_o == $past(rx_recovered_clk_int_i))
        else $error("line clock source wrong");

    line_follow_a: assert property (
        ce_i && (!atten_tx || nrz_mode)
        |=> tx_line_clk_out_o == tx_line_clk_o)
        else $error("line clock output does not follow selection");

    atten_drive_a: assert property (
        ce_i && atten_tx && !nrz_mode
        |=> tx_line_clk_out_o == $past(attenuator_clock_i))
        else $error("attenuator clock not on line output");

endmodule // clock_select_and_output_enable

// ==== hw/clock_select_pkg.sv ====
package clock_select_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [5:0] BUF_EN_IDX   = 6'h19;
    localparam logic [5:0] CLK_SEL_IDX  = 6'h1a;
    localparam logic [5:0] TEST_SEL_IDX = 6'h1b;
    localparam logic [5:0] PATH_CTL_IDX = 6'h3e;
    localparam logic [5:0] STATUS_IDX   = 6'h3f;

    ////////////////////////////////////////////////////////////////////
    // Output buffer enables, a one means three-stated
    localparam int LINK_CLK_HIZ_BIT = 5;
    localparam int RX_LINK_HIZ_BIT  = 4;
    localparam int INDICATION_BIT   = 3;
    localparam int TX_LINE_HIZ_BIT  = 2;
    localparam int ADAPTER_HIZ_BIT  = 1;
    localparam int RX_CLK_HIZ_BIT   = 0;

    ////////////////////////////////////////////////////////////////////
    // Clock source select fields, two bits each
    localparam int RX_SYSBUS_LSB = 6;
    localparam int TX_SYSBUS_LSB = 4;
    localparam int ADAPTER_LSB   = 2;
    localparam int TX_LINE_LSB   = 0;

    // Selector codes
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;
    localparam logic [1:0] SEL_D = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // Path control fields
    localparam int LINK_DIR_IN_BIT = 0;
    localparam int SLIP_BYPASS_BIT = 1;
    localparam int ADAPTER_EN_BIT  = 2;
    localparam int ATTEN_EN_BIT    = 3;
    localparam int ATTEN_TX_BIT    = 4;
    localparam int NRZ_SELECT_BIT  = 5;

    // Status fields
    localparam int NRZ_MODE_BIT    = 0;
    localparam int ATTEN_PATH_BIT  = 1;
    localparam int CLK_VIEW_LSB    = 2;

    ////////////////////////////////////////////////////////////////////
    // Synchronised clock pins
    localparam int PIN_RX_SYSBUS  = 0;
    localparam int PIN_TX_SYSBUS  = 1;
    localparam int PIN_ADAPTER    = 2;
    localparam int PIN_TX_LINE    = 3;
    localparam int PIN_COUNT      = 4;

    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [5:0] BUF_EN_RESET   = 6'h3f;
    localparam logic [7:0] CLK_SEL_RESET  = 8'h00;
    localparam logic [5:0] TEST_SEL_RESET = 6'h00;
    localparam logic [5:0] PATH_CTL_RESET = 6'h00;

endpackage

// ==== verification/backplane_model.sv ====
`timescale 1ns/1ps
module backplane_model (
    // Clock and requested pin levels
    input  wire logic       clk_i,
    input  wire logic [3:0] level_i,
    // Clock pins toward the device
    output logic      [3:0] pin_o
);
    // Pins change only after an edge, never mid-cycle, unlike a real clock
    always_ff @(posedge clk_i) begin
        pin_o <= level_i;
    end
endmodule // backplane_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        mclk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0;
    logic        penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, err;
    logic [7:0]  paddr_i = 8'h00, src = 8'h00, cs;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'hf, lvl = 4'h0;
    wire  [3:0]  pin, sel;
    wire  [15:0] pad;
    logic [19:0] ex;
    logic        ce_i = 1'b1, nrz;
    logic [5:0]  pc, be;
    int          errors, num_checks;

    // Pads land in pad as value, enable pairs
    clock_select_and_output_enable i_clock_select_and_output_enable (
        .mclk_i, .resetn_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
        .rx_sysbus_clk_pin_i(pin[0]), .tx_sysbus_clk_pin_i(pin[1]),
        .adapter_ref_pin_i(pin[2]), .tx_line_clk_pin_i(pin[3]),
        .adapter_clk_int_i(src[0]), .rx_recovered_clk_int_i(src[1]),
        .attenuator_clock_i(src[2]), .tx_link_clk_int_i(src[3]),
        .rx_neg_or_link_clk_int_i(src[4]),
        .rx_pos_or_link_data_int_i(src[5]),
        .tx_neg_or_rx_indication_int_i(src[6]),
        .tx_pos_or_tx_indication_int_i(src[7]),
        .rx_sysbus_clk_o(sel[0]), .tx_sysbus_clk_o(sel[1]),
        .adapter_ref_o(sel[2]), .tx_line_clk_o(sel[3]),
        .tx_line_clk_out_o(pad[0]), .tx_line_clk_out_oe_o(pad[1]),
        .adapter_clk_out_o(pad[2]), .adapter_clk_out_oe_o(pad[3]),
        .rx_recovered_clk_out_o(pad[4]), .rx_recovered_clk_out_oe_o(pad[5]),
        .tx_link_clk_out_o(pad[6]), .tx_link_clk_out_oe_o(pad[7]),
        .rx_neg_or_link_clk_out_o(pad[8]),
        .rx_neg_or_link_clk_out_oe_o(pad[9]),
        .rx_pos_or_link_data_out_o(pad[10]),
        .rx_pos_or_link_data_out_oe_o(pad[11]),
        .tx_neg_or_rx_indication_o(pad[12]),
        .tx_neg_or_rx_indication_oe_o(pad[13]),
        .tx_pos_or_tx_indication_o(pad[14]),
        .tx_pos_or_tx_indication_oe_o(pad[15]));

    backplane_model i_backplane_model (.clk_i(mclk_i), .level_i(lvl),
        .pin_o(pin));

    ////////////////////////////////////////////////////////////////////
    // Clock and watchdog, generous against about 1500 cycles of tests
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    initial begin
        #200000;
        errors++;
        final_report();
    end

    // One APB transfer; the extra edge holds psel low for one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    function automatic logic pick(input logic [3:0] v, input logic [1:0] c);
        return v[c];
    endfunction

    // Selected clocks, then value and enable of each pad
    function automatic logic [19:0] expect_all();
        logic       tl;
        logic [7:0] v;
        logic [7:0] o;
        logic [3:0] s;
        tl = pick({src[0], lvl[0], src[1], lvl[3]}, cs[1:0]);
        s = {tl, pick({lvl[3], lvl[1], src[1], lvl[2]}, cs[3:2]) & pc[2],
             pick({src[0], lvl[2], lvl[0], lvl[1]}, cs[5:4]) & ~pc[1],
             pick({src[0], lvl[2], lvl[1], lvl[0]}, cs[7:6])};
        v = {src[7:3], src[1:0], (pc[3] & pc[4] &
             ~(pc[5] & ~be[3] & ~be[2])) ? src[2] : tl};
        o = ~{be[3], be[3], be[4], be[4], be[5] | pc[0], be[0], be[1], be[2]};
        for (int k = 0; k < 8; k++) begin
            expect_all[2*k] = v[k];
            expect_all[2*k+1] = o[k];
        end
        expect_all[19:16] = s;
    endfunction

    initial begin
        void'($urandom(32'hdb212574));
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        chk(pad & 16'haaaa, 32'h0);
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, 32'h3f);
        apb(1'b0, 8'h65, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h6c, 32'h2a);
        apb(1'b0, 8'h6c, 32'h0);
        chk(rd, 32'h2a);
        apb(1'b1, 8'h6c, 32'h0);
        for (int i = 0; i < 64; i++) begin
            be = (i < 6) ? 6'h01 << i : 6'($urandom);
            cs = (i < 4) ? {4{i[1:0]}} : 8'($urandom);
            pc = 6'($urandom);
            apb(1'b1, 8'h64, {26'h0, be});
            apb(1'b1, 8'h68, {24'h0, cs});
            apb(1'b1, 8'hf8, {26'h0, pc});
            lvl <= 4'($urandom);
            src <= 8'($urandom);
            repeat (6) @(posedge mclk_i);
            ex = expect_all();
            chk({sel, pad}, ex);
            nrz = pc[5] & ~be[3] & ~be[2];
            apb(1'b0, 8'hfc, 32'h0);
            chk(rd, {26'h0, ex[19:16], pc[3] & pc[4], nrz});
        end
        // Clock enable low must freeze every output
        ce_i <= 1'b0;
        src <= ~src;
        lvl <= ~lvl;
        repeat (6) @(posedge mclk_i);
        chk({sel, pad}, ex);
        ce_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        chk({sel, pad}, expect_all());
        apb(1'b1, 8'hfc, 32'h0);
        chk(err, 1'b1);
        pstrb_i <= 4'he;
        apb(1'b1, 8'h64, 32'h0);
        pstrb_i <= 4'hf;
        apb(1'b0, 8'h64, 32'h0);
        chk(rd, {26'h0, be});
        final_report();
    end

    task automatic final_report();
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
endmodule // testbench
